// ### src/baud_ctrl_pkg.sv
// Constants and types shared by the baud-rate control block
package baud_ctrl_pkg;

    // ----------------------------------------------------------------
    // Register bus
    // ----------------------------------------------------------------
    typedef logic [1:0] addr_type;
    typedef logic [7:0] data_type;

    localparam addr_type CTRL_ADDR = 2'h0;
    localparam addr_type STATUS_ADDR = 2'h1;
    localparam addr_type MASK_ADDR = 2'h2;

    // ----------------------------------------------------------------
    // Control register fields
    // ----------------------------------------------------------------
    localparam int ABD_OVF_BIT = 7;
    localparam int IDLE_BIT = 6;
    localparam int GAP_HI_BIT = 5;
    localparam int POL_BIT = 4;
    localparam int WIDE_BIT = 3;
    localparam int GAP_LO_BIT = 2;
    localparam int WAKE_EN_BIT = 1;
    localparam int ABD_BIT = 0;

    // ----------------------------------------------------------------
    // Event status and mask fields
    // ----------------------------------------------------------------
    localparam int EV_W = 3;
    localparam int EV_WAKE_BIT = 0;
    localparam int EV_ABD_BIT = 1;
    localparam int EV_START_BIT = 2;
    localparam logic [EV_W-1:0] EV_NONE = 3'h0;

    // ----------------------------------------------------------------
    // Divider
    // ----------------------------------------------------------------
    localparam int DIV_W = 16;
    localparam int NARROW_W = 8;
    typedef logic [DIV_W-1:0] div_type;
    localparam div_type DIV_ZERO = 16'h0000;
    localparam div_type DIV_ONE = 16'h0001;

    localparam data_type BYTE_ZERO = 8'h00;

    typedef enum logic {
        RX_IDLE,
        RX_BUSY
    } rx_state_type;

endpackage

// ### src/line_events_if.sv
// Synchronised line levels and edges passed to the control logic
`timescale 1ns/1ns
interface line_events_if;
    logic rx_level;
    logic rx_fall;
    logic sclk_rise;
    logic sclk_fall;

    modport source (
        output rx_level,
        output rx_fall,
        output sclk_rise,
        output sclk_fall
    );
    modport sink (
        input rx_level,
        input rx_fall,
        input sclk_rise,
        input sclk_fall
    );
endinterface

// ### src/pin_edge_detect.sv
// Two-stage synchronisers and edge detection for the receive and clock pins
`timescale 1ns/1ns
module pin_edge_detect (
    input wire logic clk,
    input wire logic nrst,
    input wire logic rx_pin,
    input wire logic sclk_pin,
    line_events_if.source ev
);
    typedef struct packed {
        logic rx_meta;
        logic rx_sync;
        logic rx_prev;
        logic ck_meta;
        logic ck_sync;
        logic ck_prev;
    } edge_state_type;

    edge_state_type s_reg;
    edge_state_type s_next;

    // Idle serial line is high, so the receive stages reset high
    always_comb begin
        s_next = s_reg;
        s_next.rx_meta = rx_pin;
        s_next.rx_sync = s_reg.rx_meta;
        s_next.rx_prev = s_reg.rx_sync;
        s_next.ck_meta = sclk_pin;
        s_next.ck_sync = s_reg.ck_meta;
        s_next.ck_prev = s_reg.ck_sync;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_reg <= '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
        end else begin
            s_reg <= s_next;
        end
    end

    assign ev.rx_level = s_reg.rx_sync;
    assign ev.rx_fall = s_reg.rx_prev & ~s_reg.rx_sync;
    assign ev.sclk_rise = ~s_reg.ck_prev & s_reg.ck_sync;
    assign ev.sclk_fall = s_reg.ck_prev & ~s_reg.ck_sync;
endmodule

// ### src/baud_divider.sv
// Free-running baud-rate divider, 8 or 16 bits wide
`timescale 1ns/1ns
module baud_divider (
    input wire logic clk,
    input wire logic nrst,
    input wire logic wide,
    input wire baud_ctrl_pkg::div_type divisor,
    input wire logic restart,
    output logic tick
);
    import baud_ctrl_pkg::*;

    typedef struct packed {
        div_type count;
        logic tick;
    } div_state_type;

    div_state_type s_reg;
    div_state_type s_next;

    // Narrow mode ignores the upper divisor byte entirely
    function automatic div_type period_of(input logic w, input div_type d);
        period_of = w ? d : {{(DIV_W-NARROW_W){1'b0}}, d[NARROW_W-1:0]};
    endfunction

    always_comb begin
        s_next = s_reg;
        s_next.tick = 1'b0;
        if (restart) begin
            s_next.count = period_of(wide, divisor); // see R7
        end else if (s_reg.count == DIV_ZERO) begin
            s_next.count = period_of(wide, divisor); // see R7
            s_next.tick = 1'b1;
        end else begin
            s_next.count = s_reg.count - DIV_ONE;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_reg <= '{DIV_ZERO, 1'b0};
        end else begin
            s_reg <= s_next;
        end
    end

    assign tick = s_reg.tick;

    property p_narrow_count;
        @(posedge clk) disable iff (!nrst)
        (!wide && (restart || s_reg.count == DIV_ZERO))
            |=> s_reg.count <= period_of(1'b0, {DIV_W{1'b1}});
    endproperty
    a_narrow_count: assert property (p_narrow_count) // see R7
        else $error("narrow divider count above eight bits");
endmodule

// ### src/baud_rate_control_unit.sv
// Baud-rate control register with idle, polarity, wake and auto-rate logic
//
// Behaviour
// R1: Async idle flag is 1 when idle, 0 from start bit to end.
// R2: Async mode drives transmit data inverted when polarity select is 1.
// R3: Sync mode polarity select picks rising (1) or falling (0) data edge.
// R4: Async wake enable: falling edge sets receive flag, no character taken.
// R5: Wake enable clears itself once the wake edge set the receive flag.
// R6: Async auto-rate enable starts detection and clears itself on completion.
// R7: Divider counts eight bits by default, sixteen when wide select is set.
// R8: Sync mode ignores idle, wake and auto-rate; bits 5 and 2 read zero.
`timescale 1ns/1ns
module baud_rate_control_unit (
    input wire logic clk,
    input wire logic nrst,
    input wire baud_ctrl_pkg::addr_type addr,
    input wire baud_ctrl_pkg::data_type wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output baud_ctrl_pkg::data_type rdata,
    input wire logic sync_mode,
    input wire logic rx_pin,
    input wire logic sclk_pin,
    input wire logic tx_serial_data,
    input wire logic tx_sync_clock,
    input wire logic rx_char_done,
    input wire logic abd_complete,
    input wire logic abd_overflow,
    input wire baud_ctrl_pkg::div_type divisor,
    input wire logic divisor_load,
    output logic transmit_clock_pin,
    output logic receive_interrupt_flag_set,
    output logic auto_rate_active,
    output logic wide_divider_select,
    output logic baud_tick,
    output logic data_clock_strobe,
    output logic irq
);
    import baud_ctrl_pkg::*;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic pol;
        logic wide;
        logic wake_en;
        logic abd;
        rx_state_type rx_state;
        logic [EV_W-1:0] status;
        logic [EV_W-1:0] mask;
        data_type rdata;
        logic pin;
        logic rx_flag_set;
        logic clk_strobe;
        logic irq;
    } top_state_type;

    top_state_type s_reg;
    top_state_type s_next;

    line_events_if ev ();

    logic wake_ev;
    logic start_ev;
    logic abd_ev;
    logic ctrl_wr;
    logic [EV_W-1:0] events;

    // ----------------------------------------------------------------
    // Submodules
    // ----------------------------------------------------------------
    pin_edge_detect edges (
        .clk(clk),
        .nrst(nrst),
        .rx_pin(rx_pin),
        .sclk_pin(sclk_pin),
        .ev(ev.source)
    );

    baud_divider divider (
        .clk(clk),
        .nrst(nrst),
        .wide(s_reg.wide),
        .divisor(divisor),
        .restart(divisor_load),
        .tick(baud_tick)
    );

    // ----------------------------------------------------------------
    // Register read view
    // ----------------------------------------------------------------
    function automatic data_type ctrl_view(input top_state_type s,
                                           input logic sync,
                                           input logic ovf);
        data_type v;
        v = BYTE_ZERO;
        v[ABD_OVF_BIT] = ovf;
        // Synchronous mode has no idle meaning; it simply reads high
        v[IDLE_BIT] = sync | (s.rx_state == RX_IDLE); // see R1
        v[POL_BIT] = s.pol;
        v[WIDE_BIT] = s.wide;
        v[WAKE_EN_BIT] = s.wake_en;
        v[ABD_BIT] = s.abd;
        ctrl_view = v; // see R8
    endfunction

    function automatic data_type widen(input logic [EV_W-1:0] f);
        widen = {{(8-EV_W){1'b0}}, f};
    endfunction

    // ----------------------------------------------------------------
    // Event decode
    // ----------------------------------------------------------------
    always_comb begin
        ctrl_wr = wr_en && (addr == CTRL_ADDR);
        wake_ev = !sync_mode && s_reg.wake_en && ev.rx_fall; // see R4
        // A start bit is ignored while waking or measuring the rate
        start_ev = !sync_mode && !s_reg.wake_en && !s_reg.abd
                   && (s_reg.rx_state == RX_IDLE) && ev.rx_fall;
        abd_ev = !sync_mode && s_reg.abd && abd_complete; // see R6
        events = EV_NONE;
        events[EV_WAKE_BIT] = wake_ev;
        events[EV_ABD_BIT] = abd_ev;
        events[EV_START_BIT] = start_ev;
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        s_next = s_reg;
        s_next.rx_flag_set = 1'b0;
        s_next.rdata = BYTE_ZERO;

        unique case (s_reg.rx_state)
            RX_IDLE: begin
                if (start_ev) begin
                    s_next.rx_state = RX_BUSY; // see R1
                end
            end
            RX_BUSY: begin
                if (rx_char_done || sync_mode) begin
                    s_next.rx_state = RX_IDLE; // see R1, R8
                end
            end
        endcase

        if (wake_ev) begin
            s_next.rx_flag_set = 1'b1; // see R4
            s_next.wake_en = 1'b0; // see R5
        end
        if (abd_ev) begin
            s_next.abd = 1'b0; // see R6
        end

        // A software write in the same cycle overrides the self-clear
        if (ctrl_wr) begin
            s_next.pol = wdata[POL_BIT];
            s_next.wide = wdata[WIDE_BIT]; // see R7
            s_next.wake_en = wdata[WAKE_EN_BIT];
            s_next.abd = wdata[ABD_BIT]; // see R6
        end
        if (wr_en && (addr == MASK_ADDR)) begin
            s_next.mask = wdata[EV_W-1:0];
        end

        if (rd_en) begin
            unique case (addr)
                CTRL_ADDR: s_next.rdata = ctrl_view(s_reg, sync_mode,
                                                    abd_overflow);
                STATUS_ADDR: s_next.rdata = widen(s_reg.status);
                MASK_ADDR: s_next.rdata = widen(s_reg.mask);
                default: s_next.rdata = BYTE_ZERO;
            endcase
        end

        // Read clears, but an event in the same cycle is kept
        if (rd_en && (addr == STATUS_ADDR)) begin
            s_next.status = EV_NONE;
        end
        s_next.status = s_next.status | events;

        if (sync_mode) begin
            s_next.pin = tx_sync_clock;
        end else begin
            s_next.pin = tx_serial_data ^ s_reg.pol; // see R2
        end
        s_next.clk_strobe = sync_mode
            && (s_reg.pol ? ev.sclk_rise : ev.sclk_fall); // see R3

        s_next.irq = |(s_next.status & s_next.mask);
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_reg <= '{1'b0, 1'b0, 1'b0, 1'b0, RX_IDLE, EV_NONE, EV_NONE,
                       BYTE_ZERO, 1'b1, 1'b0, 1'b0, 1'b0};
        end else begin
            s_reg <= s_next;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign rdata = s_reg.rdata;
    assign transmit_clock_pin = s_reg.pin;
    assign receive_interrupt_flag_set = s_reg.rx_flag_set;
    assign auto_rate_active = s_reg.abd;
    assign wide_divider_select = s_reg.wide;
    assign data_clock_strobe = s_reg.clk_strobe;
    assign irq = s_reg.irq;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    property p_start_busy;
        @(posedge clk) disable iff (!nrst)
        (rd_en && addr == CTRL_ADDR && !sync_mode
            && s_reg.rx_state == RX_BUSY) |=> !rdata[IDLE_BIT];
    endproperty
    a_start_busy: assert property (p_start_busy) // see R1
        else $error("idle flag not low after start bit");

    property p_done_idle;
        @(posedge clk) disable iff (!nrst)
        (s_reg.rx_state == RX_BUSY && rx_char_done)
            |=> s_reg.rx_state == RX_IDLE;
    endproperty
    a_done_idle: assert property (p_done_idle) // see R1
        else $error("receiver not idle after character end");

    property p_async_pin;
        @(posedge clk) disable iff (!nrst)
        !sync_mode |=> transmit_clock_pin
            == ($past(tx_serial_data) ^ $past(s_reg.pol));
    endproperty
    a_async_pin: assert property (p_async_pin) // see R2
        else $error("transmit pin polarity wrong");

    property p_edge_pick;
        @(posedge clk) disable iff (!nrst)
        (sync_mode && s_reg.pol && ev.sclk_rise)
            or (sync_mode && !s_reg.pol && ev.sclk_fall)
            |=> data_clock_strobe;
    endproperty
    a_edge_pick: assert property (p_edge_pick) // see R3
        else $error("selected clock edge not strobed");

    property p_edge_cause;
        @(posedge clk) disable iff (!nrst)
        data_clock_strobe |-> $past(sync_mode)
            && ($past(s_reg.pol) ? $past(ev.sclk_rise)
                                 : $past(ev.sclk_fall));
    endproperty
    a_edge_cause: assert property (p_edge_cause) // see R3
        else $error("strobe on wrong clock edge");

    property p_wake_flag;
        @(posedge clk) disable iff (!nrst)
        wake_ev |=> receive_interrupt_flag_set
            && s_reg.rx_state == RX_IDLE;
    endproperty
    a_wake_flag: assert property (p_wake_flag) // see R4
        else $error("wake edge did not set receive flag");

    property p_wake_clear;
        @(posedge clk) disable iff (!nrst)
        (wake_ev && !ctrl_wr)
            |=> !s_reg.wake_en ##1 !receive_interrupt_flag_set;
    endproperty
    a_wake_clear: assert property (p_wake_clear) // see R5
        else $error("wake enable not cleared after wake");

    property p_abd_clear;
        @(posedge clk) disable iff (!nrst)
        (abd_ev && !ctrl_wr) |=> !auto_rate_active;
    endproperty
    a_abd_clear: assert property (p_abd_clear) // see R6
        else $error("auto-rate enable not cleared on completion");

    property p_gap_zero;
        @(posedge clk) disable iff (!nrst)
        (rd_en && addr == CTRL_ADDR)
            |=> !rdata[GAP_HI_BIT] && !rdata[GAP_LO_BIT];
    endproperty
    a_gap_zero: assert property (p_gap_zero) // see R8
        else $error("unimplemented control bits read nonzero");

    property p_sync_quiet;
        @(posedge clk) disable iff (!nrst)
        sync_mode [*2] |-> !receive_interrupt_flag_set;
    endproperty
    a_sync_quiet: assert property (p_sync_quiet) // see R8
        else $error("wake acted in synchronous mode");

    c_wake: cover property (@(posedge clk) disable iff (!nrst)
        wake_ev ##1 receive_interrupt_flag_set);
    c_abd: cover property (@(posedge clk) disable iff (!nrst)
        auto_rate_active ##[1:20] !auto_rate_active);
    c_char: cover property (@(posedge clk) disable iff (!nrst)
        start_ev ##[1:50] rx_char_done);
    c_irq: cover property (@(posedge clk) disable iff (!nrst)
        irq ##1 (rd_en && addr == STATUS_ADDR));
endmodule

// ### test/remote_station.sv
// Behavioural remote serial station driving the receive and clock pins
`timescale 1ns/1ns
module remote_station (
    input wire logic clk,
    output logic rx_pin,
    output logic sclk_pin
);
    // Line rests at its pull-up level; clock stands still outside frames
    initial begin
        rx_pin = 1'b1;
        sclk_pin = 1'b0;
    end

    // ----------------------------------------------------------------
    // Line actions
    // ----------------------------------------------------------------
    task automatic start_bit(input int low_cycles);
        @(posedge clk) rx_pin <= 1'b0;
        repeat (low_cycles) @(posedge clk);
        rx_pin <= 1'b1;
    endtask

    // One clock period; the device picks which edge moves data
    task automatic clock_pulse(input int half);
        @(posedge clk) sclk_pin <= 1'b1;
        repeat (half) @(posedge clk);
        sclk_pin <= 1'b0;
        repeat (half) @(posedge clk);
    endtask
endmodule

// ### test/tb_baud_rate_control_unit.sv
// Register-level testbench for the baud-rate control block
`timescale 1ns/1ns
module tb_baud_rate_control_unit;
    import baud_ctrl_pkg::*;

    logic clk = 1'b0;
    logic nrst = 1'b0;
    addr_type addr = CTRL_ADDR;
    data_type wdata = BYTE_ZERO;
    logic wr_en = 1'b0, rd_en = 1'b0;
    logic sync_mode = 1'b0, tx_serial_data = 1'b0, tx_sync_clock = 1'b0;
    logic rx_char_done = 1'b0, abd_complete = 1'b0, abd_overflow = 1'b0;
    logic divisor_load = 1'b0;
    div_type divisor = DIV_ZERO;
    logic rx_pin, sclk_pin;
    data_type rdata;
    logic transmit_clock_pin, receive_interrupt_flag_set, auto_rate_active;
    logic wide_divider_select, baud_tick, data_clock_strobe, irq;
    int failures = 0;
    int checked = 0;
    int n;

    always #5 clk = ~clk;

    baud_rate_control_unit i_baud_rate_control_unit (
        .clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
        .sync_mode(sync_mode), .rx_pin(rx_pin), .sclk_pin(sclk_pin),
        .tx_serial_data(tx_serial_data), .tx_sync_clock(tx_sync_clock),
        .rx_char_done(rx_char_done), .abd_complete(abd_complete),
        .abd_overflow(abd_overflow), .divisor(divisor),
        .divisor_load(divisor_load),
        .transmit_clock_pin(transmit_clock_pin),
        .receive_interrupt_flag_set(receive_interrupt_flag_set),
        .auto_rate_active(auto_rate_active),
        .wide_divider_select(wide_divider_select), .baud_tick(baud_tick),
        .data_clock_strobe(data_clock_strobe), .irq(irq)
    );

    remote_station i_remote_station (
        .clk(clk), .rx_pin(rx_pin), .sclk_pin(sclk_pin)
    );

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic stop_test();
        if (failures == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp,
                         input string msg);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    task automatic wr(input addr_type a, input data_type d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input addr_type a, input data_type exp,
                      input string msg);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 check({8'h00, rdata}, {8'h00, exp}, msg);
    endtask

    task automatic pulse_in(input int sel);
        @(posedge clk);
        case (sel)
            0: rx_char_done <= 1'b1;
            1: abd_complete <= 1'b1;
            default: divisor_load <= 1'b1;
        endcase
        @(posedge clk);
        rx_char_done <= 1'b0;
        abd_complete <= 1'b0;
        divisor_load <= 1'b0;
    endtask

    // Bounded wait for an output pulse; cycles taken come back in cnt
    task automatic wait_sig(input int sel, input int lim, output int cnt);
        logic v;
        cnt = 0;
        do begin
            @(posedge clk);
            #1 cnt++;
            v = (sel == 0) ? receive_interrupt_flag_set :
                (sel == 1) ? data_clock_strobe : baud_tick;
        end while (v !== 1'b1 && cnt < lim);
        if (v !== 1'b1) begin
            failures++;
            $display("[FAIL] %0t wait limit reached", $time);
            stop_test();
        end
    endtask

    task automatic settle(input int cyc);
        repeat (cyc) @(posedge clk);
        #1;
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        rd(CTRL_ADDR, 8'h40, "reset control");
        rd(MASK_ADDR, 8'h00, "reset mask");
        // Bits 7,6,5,2 not writable, bits 5 and 2 read zero
        wr(CTRL_ADDR, 8'hBC);
        rd(CTRL_ADDR, 8'h58, "control write");
        check(wide_divider_select, 1'b1, "wide select");
        tx_serial_data <= 1'b1;
        settle(3);
        check(transmit_clock_pin, 1'b0, "inverted tx");
        wr(CTRL_ADDR, 8'h00);
        settle(3);
        check(transmit_clock_pin, 1'b1, "plain tx");
        // Divider period is divisor+1, low byte only when narrow
        divisor <= 16'h0102;
        pulse_in(2);
        wait_sig(2, 300, n);
        wait_sig(2, 400, n);
        check(n, 3, "narrow period");
        wr(CTRL_ADDR, 8'h08);
        pulse_in(2);
        wait_sig(2, 400, n);
        wait_sig(2, 400, n);
        check(n, 259, "wide period");
        // Wake on falling edge, no character, self-clearing enable
        wr(MASK_ADDR, 8'h01);
        wr(CTRL_ADDR, 8'h02);
        fork
            i_remote_station.start_bit(20);
            wait_sig(0, 10, n);
        join
        check(irq, 1'b1, "wake irq");
        rd(CTRL_ADDR, 8'h40, "wake cleared, idle kept");
        rd(STATUS_ADDR, 8'h01, "wake status");
        rd(STATUS_ADDR, 8'h00, "status cleared");
        check(irq, 1'b0, "irq dropped");
        // Start bit makes the receiver busy until the character ends
        fork
            i_remote_station.start_bit(6);
        join
        rd(CTRL_ADDR, 8'h00, "busy");
        pulse_in(0);
        rd(CTRL_ADDR, 8'h40, "idle again");
        // Auto-rate detection clears its enable on completion
        wr(CTRL_ADDR, 8'h01);
        settle(1);
        check(auto_rate_active, 1'b1, "auto-rate on");
        pulse_in(1);
        settle(1);
        check(auto_rate_active, 1'b0, "auto-rate done");
        check(irq, 1'b0, "masked event");
        rd(CTRL_ADDR, 8'h40, "auto-rate bit clear");
        wr(MASK_ADDR, 8'h02);
        settle(1);
        check(irq, 1'b1, "unmasked event");
        // Start event from the earlier start bit is still sticky
        rd(STATUS_ADDR, 8'h06, "auto-rate status");
        // Synchronous mode: edge choice, pin follows generated clock
        sync_mode <= 1'b1;
        abd_overflow <= 1'b1;
        wr(CTRL_ADDR, 8'h13);
        rd(CTRL_ADDR, 8'hD3, "sync view");
        fork
            i_remote_station.clock_pulse(10);
            wait_sig(1, 8, n);
            i_remote_station.start_bit(6);
            pulse_in(1);
        join
        rd(CTRL_ADDR, 8'hD3, "sync ignores wake and rate");
        rd(STATUS_ADDR, 8'h00, "no sync events");
        wr(CTRL_ADDR, 8'h00);
        fork
            i_remote_station.clock_pulse(10);
            wait_sig(1, 20, n);
        join
        check(n > 10, 1'b1, "falling edge strobe");
        tx_sync_clock <= 1'b1;
        settle(3);
        check(transmit_clock_pin, 1'b1, "sync clock out");
        tx_sync_clock <= 1'b0;
        settle(3);
        check(transmit_clock_pin, 1'b0, "sync clock low");
        rd(2'h3, 8'h00, "unmapped");
        stop_test();
    end
endmodule
